// ### include/hptr_defs.svh
// Register offsets, field positions and reset values of the hub port trim bank.
`ifndef HPTR_DEFS_SVH
`define HPTR_DEFS_SVH
`define HPTR_ADDR_W            16
`define HPTR_P2_SQ_OFS         16'h68CC
`define HPTR_P2_LINK_OFS       16'h69C0
`define HPTR_P3_DRV_OFS        16'h6CCA
`define HPTR_P3_SQ_OFS         16'h6CCC
`define HPTR_P3_LINK_OFS       16'h6DC0
`define HPTR_P4_DRV_OFS        16'h70CA
`define HPTR_P4_SQ_OFS         16'h70CC
`define HPTR_TRIM_MSB          2
`define HPTR_RSVD_LSB          3
`define HPTR_STATE_LSB         4
`define HPTR_SQ_RESET          3'h0
`define HPTR_DRV_RESET         3'h0
`define HPTR_UNMAPPED_DATA     8'h00
`endif

// ### include/hptr_pkg.sv
// Types shared by the hub port trim bank.
package hptr_pkg;
   // Link state codes presented in bits 7:4 of a link status register.
   typedef enum logic [3:0] {
      HPTR_LS_U0          = 4'h0,
      HPTR_LS_U1          = 4'h1,
      HPTR_LS_U2          = 4'h2,
      HPTR_LS_U3          = 4'h3,
      HPTR_LS_DISABLED    = 4'h4,
      HPTR_LS_RX_DETECT   = 4'h5,
      HPTR_LS_INACTIVE    = 4'h6,
      HPTR_LS_POLLING     = 4'h7,
      HPTR_LS_RECOVERY    = 4'h8,
      HPTR_LS_HOT_RESET   = 4'h9,
      HPTR_LS_COMPLIANCE  = 4'hA,
      HPTR_LS_LOOPBACK    = 4'hB
   } hptr_link_state_t;
   // Squelch trip point codes; reductions in 12.5 mV steps, two raises.
   typedef enum logic [2:0] {
      HPTR_SQ_NOMINAL  = 3'h0,
      HPTR_SQ_DN_12P5  = 3'h1,
      HPTR_SQ_DN_25    = 3'h2,
      HPTR_SQ_DN_37P5  = 3'h3,
      HPTR_SQ_DN_50    = 3'h4,
      HPTR_SQ_DN_62P5  = 3'h5,
      HPTR_SQ_UP_25    = 3'h6,
      HPTR_SQ_UP_12P5  = 3'h7
   } hptr_squelch_t;
   // Drive current codes.
   typedef enum logic [2:0] {
      HPTR_DRV_NOMINAL = 3'h0,
      HPTR_DRV_DN_5    = 3'h1,
      HPTR_DRV_UP_10   = 3'h2,
      HPTR_DRV_UP_5    = 3'h3,
      HPTR_DRV_UP_20   = 3'h4,
      HPTR_DRV_UP_15   = 3'h5,
      HPTR_DRV_UP_30   = 3'h6,
      HPTR_DRV_UP_25   = 3'h7
   } hptr_drive_t;
endpackage

// ### rtl/hptr_regs.sv
// Register bank holding port 2 to 4 transceiver trims and port 2 and 3 link status.
`timescale 1ns/1ps
`default_nettype none
`include "hptr_defs.svh"

module hptr_regs (
   input  wire logic                     clk,
   input  wire logic                     sys_rst,
   input  wire logic [`HPTR_ADDR_W-1:0]  reg_addr,
   input  wire logic [7:0]               reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output var  logic [7:0]               reg_rdata,
   input  wire hptr_pkg::hptr_link_state_t port2_link_state,
   input  wire logic [2:0]               port2_link_sub_state,
   input  wire hptr_pkg::hptr_link_state_t port3_link_state,
   input  wire logic [2:0]               port3_link_sub_state,
   output var  hptr_pkg::hptr_squelch_t  port2_squelch_trim_code,
   output var  hptr_pkg::hptr_squelch_t  port3_squelch_trim_code,
   output var  hptr_pkg::hptr_squelch_t  port4_squelch_trim_code,
   output var  hptr_pkg::hptr_drive_t    port3_drive_current_trim_code,
   output var  hptr_pkg::hptr_drive_t    port4_drive_current_trim_code
);

   // ****************************************************************
   // Software writes
   // ****************************************************************
   // The trim outputs are the storage flip-flops themselves, so the analogue
   // side sees a new code in the cycle after the write strobe.
   logic [7:`HPTR_RSVD_LSB] port3_drv_rsvd;
   logic [7:`HPTR_RSVD_LSB] port4_drv_rsvd;

   function automatic logic hit(input logic [`HPTR_ADDR_W-1:0] a, input logic [`HPTR_ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         port2_squelch_trim_code <= hptr_pkg::hptr_squelch_t'(`HPTR_SQ_RESET);
         port3_squelch_trim_code <= hptr_pkg::hptr_squelch_t'(`HPTR_SQ_RESET);
         port4_squelch_trim_code <= hptr_pkg::hptr_squelch_t'(`HPTR_SQ_RESET);
      end else if (reg_wr) begin
         // Only the low three bits are kept; upper bits are dropped.
         if (hit(reg_addr, `HPTR_P2_SQ_OFS))
            port2_squelch_trim_code <= hptr_pkg::hptr_squelch_t'(reg_wdata[`HPTR_TRIM_MSB:0]);
         if (hit(reg_addr, `HPTR_P3_SQ_OFS))
            port3_squelch_trim_code <= hptr_pkg::hptr_squelch_t'(reg_wdata[`HPTR_TRIM_MSB:0]);
         if (hit(reg_addr, `HPTR_P4_SQ_OFS))
            port4_squelch_trim_code <= hptr_pkg::hptr_squelch_t'(reg_wdata[`HPTR_TRIM_MSB:0]);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         port3_drive_current_trim_code <= hptr_pkg::hptr_drive_t'(`HPTR_DRV_RESET);
         port4_drive_current_trim_code <= hptr_pkg::hptr_drive_t'(`HPTR_DRV_RESET);
         port3_drv_rsvd                <= '0;
         port4_drv_rsvd                <= '0;
      end else if (reg_wr) begin
         if (hit(reg_addr, `HPTR_P3_DRV_OFS)) begin
            port3_drive_current_trim_code <= hptr_pkg::hptr_drive_t'(reg_wdata[`HPTR_TRIM_MSB:0]);
            port3_drv_rsvd                <= reg_wdata[7:`HPTR_RSVD_LSB];
         end
         if (hit(reg_addr, `HPTR_P4_DRV_OFS)) begin
            port4_drive_current_trim_code <= hptr_pkg::hptr_drive_t'(reg_wdata[`HPTR_TRIM_MSB:0]);
            port4_drv_rsvd                <= reg_wdata[7:`HPTR_RSVD_LSB];
         end
      end
   end

   // ****************************************************************
   // Read path
   // ****************************************************************
   // Link status is sampled at the read strobe, so software sees the state
   // as it stood in the strobe cycle; bit 3 of a link status read is always zero.
   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = `HPTR_UNMAPPED_DATA;
      unique case (reg_addr)
         `HPTR_P2_SQ_OFS:   next_rdata = {5'h00, port2_squelch_trim_code};
         `HPTR_P3_SQ_OFS:   next_rdata = {5'h00, port3_squelch_trim_code};
         `HPTR_P4_SQ_OFS:   next_rdata = {5'h00, port4_squelch_trim_code};
         `HPTR_P3_DRV_OFS:  next_rdata = {port3_drv_rsvd, port3_drive_current_trim_code};
         `HPTR_P4_DRV_OFS:  next_rdata = {port4_drv_rsvd, port4_drive_current_trim_code};
         `HPTR_P2_LINK_OFS: next_rdata = {port2_link_state, 1'b0, port2_link_sub_state};
         `HPTR_P3_LINK_OFS: next_rdata = {port3_link_state, 1'b0, port3_link_sub_state};
         default:           next_rdata = `HPTR_UNMAPPED_DATA;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= next_rdata;
      else
         reg_rdata <= 8'h00;
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_sq_write_low: assert property (reg_wr && reg_addr == `HPTR_P2_SQ_OFS |=>
      port2_squelch_trim_code == $past(reg_wdata[2:0]))
      else $error("port 2 squelch code not taken from write");
   a_sq_rsvd_zero: assert property (reg_rd && reg_addr == `HPTR_P3_SQ_OFS |=> reg_rdata[7:3] == 5'h00)
      else $error("squelch reserved bits not zero");
   a_sq_codes_hold: assert property (!(reg_wr && reg_addr == `HPTR_P4_SQ_OFS) |=> $stable(port4_squelch_trim_code))
      else $error("port 4 squelch code changed without write");
   a_drv_write_low: assert property (reg_wr && reg_addr == `HPTR_P3_DRV_OFS |=>
      port3_drive_current_trim_code == $past(reg_wdata[2:0]))
      else $error("port 3 drive code not taken from write");
   a_drv_hold: assert property (!(reg_wr && reg_addr == `HPTR_P4_DRV_OFS) |=> $stable(port4_drive_current_trim_code))
      else $error("port 4 drive code changed without write");
   a_drv_rsvd_back: assert property (reg_wr && reg_addr == `HPTR_P3_DRV_OFS ##1 reg_rd && reg_addr == `HPTR_P3_DRV_OFS
      |=> reg_rdata == $past(reg_wdata, 2))
      else $error("drive register not read back as written");
   a_link_state_rd: assert property (reg_rd && reg_addr == `HPTR_P2_LINK_OFS |=>
      reg_rdata[7:4] == $past(port2_link_state))
      else $error("port 2 link state not presented");
   a_link_sub_rd: assert property (reg_rd && reg_addr == `HPTR_P3_LINK_OFS |=>
      reg_rdata[3:0] == {1'b0, $past(port3_link_sub_state)})
      else $error("port 3 sub-state or reserved bit wrong");
   a_link_code_rd: assert property (reg_rd && reg_addr == `HPTR_P3_LINK_OFS |=>
      reg_rdata[7:4] == $past(port3_link_state))
      else $error("port 3 link state not presented");
   a_unmapped_zero: assert property (reg_rd && reg_addr == `HPTR_P2_LINK_OFS + 16'h0001 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_idle_rdata: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read answer");

   // ****************************************************************
   // Squelch trim checks
   // ****************************************************************
   // Each code is checked against its named trip point, so a swapped pair of
   // codes in the decode would be caught even though the storage is a copy.
   a_sq2_hold: assert property (!(reg_wr && reg_addr == `HPTR_P2_SQ_OFS) |=>
      $stable(port2_squelch_trim_code))
      else $error("port 2 squelch code changed without write");
   a_sq3_hold: assert property (!(reg_wr && reg_addr == `HPTR_P3_SQ_OFS) |=>
      $stable(port3_squelch_trim_code))
      else $error("port 3 squelch code changed without write");
   a_sq3_write_low: assert property (reg_wr && reg_addr == `HPTR_P3_SQ_OFS |=>
      port3_squelch_trim_code == $past(reg_wdata[2:0]))
      else $error("port 3 squelch code not taken from write");
   a_sq4_write_low: assert property (reg_wr && reg_addr == `HPTR_P4_SQ_OFS |=>
      port4_squelch_trim_code == $past(reg_wdata[2:0]))
      else $error("port 4 squelch code not taken from write");
   a_sq2_rsvd_zero: assert property (reg_rd && reg_addr == `HPTR_P2_SQ_OFS |=>
      reg_rdata[7:3] == 5'h00)
      else $error("port 2 squelch reserved bits not zero");
   a_sq4_rsvd_zero: assert property (reg_rd && reg_addr == `HPTR_P4_SQ_OFS |=>
      reg_rdata[7:3] == 5'h00)
      else $error("port 4 squelch reserved bits not zero");
   a_sq2_read_back: assert property (reg_rd && reg_addr == `HPTR_P2_SQ_OFS |=>
      reg_rdata[2:0] == $past(port2_squelch_trim_code))
      else $error("port 2 squelch code not read back");
   a_sq3_read_back: assert property (reg_rd && reg_addr == `HPTR_P3_SQ_OFS |=>
      reg_rdata[2:0] == $past(port3_squelch_trim_code))
      else $error("port 3 squelch code not read back");
   a_sq4_read_back: assert property (reg_rd && reg_addr == `HPTR_P4_SQ_OFS |=>
      reg_rdata[2:0] == $past(port4_squelch_trim_code))
      else $error("port 4 squelch code not read back");
   a_sq_up25_code: assert property (reg_wr && reg_addr == `HPTR_P2_SQ_OFS && reg_wdata[2:0] == 3'h6 |=>
      port2_squelch_trim_code == hptr_pkg::HPTR_SQ_UP_25)
      else $error("squelch code six is not the 25 mV raise");
   a_sq_up12_code: assert property (reg_wr && reg_addr == `HPTR_P2_SQ_OFS && reg_wdata[2:0] == 3'h7 |=>
      port2_squelch_trim_code == hptr_pkg::HPTR_SQ_UP_12P5)
      else $error("squelch code seven is not the 12.5 mV raise");
   a_sq_dn62_code: assert property (reg_wr && reg_addr == `HPTR_P3_SQ_OFS && reg_wdata[2:0] == 3'h5 |=>
      port3_squelch_trim_code == hptr_pkg::HPTR_SQ_DN_62P5)
      else $error("squelch code five is not the 62.5 mV drop");
   a_sq_nominal_code: assert property (reg_wr && reg_addr == `HPTR_P4_SQ_OFS && reg_wdata[2:0] == 3'h0 |=>
      port4_squelch_trim_code == hptr_pkg::HPTR_SQ_NOMINAL)
      else $error("squelch code zero is not nominal");
   a_sq_dn25_code: assert property (reg_wr && reg_addr == `HPTR_P2_SQ_OFS && reg_wdata[2:0] == 3'h2 |=>
      port2_squelch_trim_code == hptr_pkg::HPTR_SQ_DN_25)
      else $error("squelch code two is not the 25 mV drop");
   a_sq_dn50_code: assert property (reg_wr && reg_addr == `HPTR_P3_SQ_OFS && reg_wdata[2:0] == 3'h4 |=>
      port3_squelch_trim_code == hptr_pkg::HPTR_SQ_DN_50)
      else $error("squelch code four is not the 50 mV drop");
   a_sq_dn37_code: assert property (reg_wr && reg_addr == `HPTR_P4_SQ_OFS && reg_wdata[2:0] == 3'h3 |=>
      port4_squelch_trim_code == hptr_pkg::HPTR_SQ_DN_37P5)
      else $error("squelch code three is not the 37.5 mV drop");
   a_sq_dn12_code: assert property (reg_wr && reg_addr == `HPTR_P2_SQ_OFS && reg_wdata[2:0] == 3'h1 |=>
      port2_squelch_trim_code == hptr_pkg::HPTR_SQ_DN_12P5)
      else $error("squelch code one is not the 12.5 mV drop");

   // ****************************************************************
   // Drive current trim checks
   // ****************************************************************
   a_drv4_write_low: assert property (reg_wr && reg_addr == `HPTR_P4_DRV_OFS |=>
      port4_drive_current_trim_code == $past(reg_wdata[2:0]))
      else $error("port 4 drive code not taken from write");
   a_drv3_hold: assert property (!(reg_wr && reg_addr == `HPTR_P3_DRV_OFS) |=>
      $stable(port3_drive_current_trim_code))
      else $error("port 3 drive code changed without write");
   a_drv3_read_low: assert property (reg_rd && reg_addr == `HPTR_P3_DRV_OFS |=>
      reg_rdata[2:0] == $past(port3_drive_current_trim_code))
      else $error("port 3 drive code not read back");
   a_drv4_read_low: assert property (reg_rd && reg_addr == `HPTR_P4_DRV_OFS |=>
      reg_rdata[2:0] == $past(port4_drive_current_trim_code))
      else $error("port 4 drive code not read back");
   a_drv3_rsvd_read: assert property (reg_rd && reg_addr == `HPTR_P3_DRV_OFS |=>
      reg_rdata[7:3] == $past(port3_drv_rsvd))
      else $error("port 3 drive reserved bits not read back");
   a_drv4_rsvd_read: assert property (reg_rd && reg_addr == `HPTR_P4_DRV_OFS |=>
      reg_rdata[7:3] == $past(port4_drv_rsvd))
      else $error("port 4 drive reserved bits not read back");
   a_drv3_rsvd_hold: assert property (!(reg_wr && reg_addr == `HPTR_P3_DRV_OFS) |=>
      $stable(port3_drv_rsvd))
      else $error("port 3 drive reserved bits changed without write");
   a_drv4_rsvd_hold: assert property (!(reg_wr && reg_addr == `HPTR_P4_DRV_OFS) |=>
      $stable(port4_drv_rsvd))
      else $error("port 4 drive reserved bits changed without write");
   a_drv_up30_code: assert property (reg_wr && reg_addr == `HPTR_P3_DRV_OFS && reg_wdata[2:0] == 3'h6 |=>
      port3_drive_current_trim_code == hptr_pkg::HPTR_DRV_UP_30)
      else $error("drive code six is not the 30 percent raise");
   a_drv_up20_code: assert property (reg_wr && reg_addr == `HPTR_P4_DRV_OFS && reg_wdata[2:0] == 3'h4 |=>
      port4_drive_current_trim_code == hptr_pkg::HPTR_DRV_UP_20)
      else $error("drive code four is not the 20 percent raise");
   a_drv_up15_code: assert property (reg_wr && reg_addr == `HPTR_P3_DRV_OFS && reg_wdata[2:0] == 3'h5 |=>
      port3_drive_current_trim_code == hptr_pkg::HPTR_DRV_UP_15)
      else $error("drive code five is not the 15 percent raise");
   a_drv_up25_code: assert property (reg_wr && reg_addr == `HPTR_P4_DRV_OFS && reg_wdata[2:0] == 3'h7 |=>
      port4_drive_current_trim_code == hptr_pkg::HPTR_DRV_UP_25)
      else $error("drive code seven is not the 25 percent raise");
   a_drv_dn5_code: assert property (reg_wr && reg_addr == `HPTR_P3_DRV_OFS && reg_wdata[2:0] == 3'h1 |=>
      port3_drive_current_trim_code == hptr_pkg::HPTR_DRV_DN_5)
      else $error("drive code one is not the 5 percent drop");
   a_drv_up10_code: assert property (reg_wr && reg_addr == `HPTR_P4_DRV_OFS && reg_wdata[2:0] == 3'h2 |=>
      port4_drive_current_trim_code == hptr_pkg::HPTR_DRV_UP_10)
      else $error("drive code two is not the 10 percent raise");
   a_drv_up5_code: assert property (reg_wr && reg_addr == `HPTR_P3_DRV_OFS && reg_wdata[2:0] == 3'h3 |=>
      port3_drive_current_trim_code == hptr_pkg::HPTR_DRV_UP_5)
      else $error("drive code three is not the 5 percent raise");

   // ****************************************************************
   // Link status and ignored write checks
   // ****************************************************************
   a_link2_sub_rd: assert property (reg_rd && reg_addr == `HPTR_P2_LINK_OFS |=>
      reg_rdata[2:0] == $past(port2_link_sub_state))
      else $error("port 2 sub-state not presented");
   a_link2_rsvd_zero: assert property (reg_rd && reg_addr == `HPTR_P2_LINK_OFS |=>
      reg_rdata[3] == 1'b0)
      else $error("port 2 link reserved bit not zero");
   a_link3_rsvd_zero: assert property (reg_rd && reg_addr == `HPTR_P3_LINK_OFS |=>
      reg_rdata[3] == 1'b0)
      else $error("port 3 link reserved bit not zero");
   // A write to a read-only or unmapped address must leave every trim alone.
   a_link2_wr_ignored: assert property (reg_wr && reg_addr == `HPTR_P2_LINK_OFS |=>
      $stable(port2_squelch_trim_code) && $stable(port3_drive_current_trim_code) && $stable(port4_drv_rsvd))
      else $error("write to port 2 link status had an effect");
   a_link3_wr_ignored: assert property (reg_wr && reg_addr == `HPTR_P3_LINK_OFS |=>
      $stable(port3_squelch_trim_code) && $stable(port4_drive_current_trim_code) && $stable(port3_drv_rsvd))
      else $error("write to port 3 link status had an effect");
   a_unmapped_wr: assert property (reg_wr && reg_addr == `HPTR_P2_SQ_OFS + 16'h0001 |=>
      $stable(port2_squelch_trim_code) && $stable(port4_squelch_trim_code))
      else $error("write to unmapped address had an effect");

   // ****************************************************************
   // Reset checks
   // ****************************************************************
   // These must run while reset is high, so they override the default disable.
   a_rst_sq: assert property (disable iff (1'b0) sys_rst |=>
      port2_squelch_trim_code == hptr_pkg::HPTR_SQ_NOMINAL && port3_squelch_trim_code == hptr_pkg::HPTR_SQ_NOMINAL
      && port4_squelch_trim_code == hptr_pkg::HPTR_SQ_NOMINAL)
      else $error("squelch codes not nominal after reset");
   a_rst_drv: assert property (disable iff (1'b0) sys_rst |=>
      port3_drive_current_trim_code == hptr_pkg::HPTR_DRV_NOMINAL
      && port4_drive_current_trim_code == hptr_pkg::HPTR_DRV_NOMINAL)
      else $error("drive codes not nominal after reset");
   a_rst_drv_rsvd: assert property (disable iff (1'b0) sys_rst |=>
      port3_drv_rsvd == 5'h00 && port4_drv_rsvd == 5'h00)
      else $error("drive reserved bits not cleared by reset");
   a_rst_rdata: assert property (disable iff (1'b0) sys_rst |=> reg_rdata == 8'h00)
      else $error("read data not zero after reset");

   c_sq_write:   cover property (reg_wr && reg_addr == `HPTR_P2_SQ_OFS && reg_wdata[2:0] == 3'h6);
   c_drv_rsvd:   cover property (reg_wr && reg_addr == `HPTR_P4_DRV_OFS && reg_wdata[7:3] != 5'h00);
   c_link_rd:    cover property (reg_rd && reg_addr == `HPTR_P2_LINK_OFS && port2_link_state == hptr_pkg::HPTR_LS_LOOPBACK);
   c_back2back:  cover property (reg_wr ##1 reg_rd);
   c_unmapped:   cover property (reg_rd && reg_addr == `HPTR_P2_LINK_OFS + 16'h0001);

endmodule
`default_nettype wire

// ### dv/tb_hptr_regs.sv
// Self-checking testbench for the hub port trim register bank.
`timescale 1ns/1ps
`default_nettype none
`include "hptr_defs.svh"
module tb_hptr_regs;
   logic                       clk = 1'b0;
   logic                       sys_rst = 1'b1;
   logic [`HPTR_ADDR_W-1:0]    reg_addr = 16'h0000;
   logic [7:0]                 reg_wdata = 8'h00;
   logic                       reg_wr = 1'b0;
   logic                       reg_rd = 1'b0;
   logic [7:0]                 reg_rdata;
   hptr_pkg::hptr_link_state_t p2_ls = hptr_pkg::HPTR_LS_U0;
   hptr_pkg::hptr_link_state_t p3_ls = hptr_pkg::HPTR_LS_U0;
   logic [2:0]                 p2_sub = 3'h0;
   logic [2:0]                 p3_sub = 3'h0;
   hptr_pkg::hptr_squelch_t    sq2, sq3, sq4;
   hptr_pkg::hptr_drive_t      dr3, dr4;
   int                         err_count = 0;
   int                         samples_checked = 0;
   logic [7:0]                 v, d, r;
   always #5 clk = ~clk;
   hptr_regs dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port2_link_state(p2_ls),
      .port2_link_sub_state(p2_sub), .port3_link_state(p3_ls), .port3_link_sub_state(p3_sub),
      .port2_squelch_trim_code(sq2), .port3_squelch_trim_code(sq3), .port4_squelch_trim_code(sq4),
      .port3_drive_current_trim_code(dr3), .port4_drive_current_trim_code(dr4));
   // ****************************************
   // Bus cycles and comparison
   // ****************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] x);
      @(posedge clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= x;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   // Read data stand only in the cycle after the strobe, so it is sampled just past that edge.
   task automatic rd(input logic [15:0] a, output logic [7:0] x);
      @(posedge clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 x = reg_rdata;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      chk({2'h0, sq2, sq4}, 8'h00);
      chk({2'h0, sq3, dr3}, 8'h00);
      rd(`HPTR_P3_DRV_OFS, r); chk(r, 8'h00);
      rd(`HPTR_P4_SQ_OFS, r); chk(r, 8'h00);
      chk({5'h00, dr4}, 8'h00);
   endtask
   // Write then read the same register with no gap; the answer stands one cycle.
   task automatic t_b2b;
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= `HPTR_P3_DRV_OFS;
      reg_wdata <= 8'hFB;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, 8'hFB);
      @(posedge clk);
      #1 chk(reg_rdata, 8'h00);
   endtask
   // Reset in mid-run must bring the port 3 squelch and port 4 drive trims back to nominal.
   task automatic t_rerst;
      wr(`HPTR_P4_DRV_OFS, 8'hC5);
      wr(`HPTR_P3_SQ_OFS, 8'h03);
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1 chk({2'h0, sq3, dr4}, 8'h00);
      rd(`HPTR_P4_DRV_OFS, r); chk(r, 8'h00);
   endtask
   task automatic t_drive;
      for (v = 8'h00; v < 8'h08; v++) begin
         d = {v[4:0] ^ 5'h1A, v[2:0]};
         wr(`HPTR_P3_DRV_OFS, d); chk({5'h00, dr3}, {5'h00, d[2:0]});
         wr(`HPTR_P4_DRV_OFS, ~d); chk({5'h00, dr4}, {5'h00, ~d[2:0]});
         rd(`HPTR_P3_DRV_OFS, r); chk(r, d);
         rd(`HPTR_P4_DRV_OFS, r); chk(r, ~d);
      end
   endtask
   task automatic t_squelch;
      for (v = 8'h00; v < 8'h08; v++) begin
         d = {v[4:0] ^ 5'h0D, v[2:0]};
         wr(`HPTR_P2_SQ_OFS, d); wr(`HPTR_P3_SQ_OFS, ~d); wr(`HPTR_P4_SQ_OFS, d ^ 8'hFE);
         chk({5'h00, sq2}, {5'h00, d[2:0]});
         chk({5'h00, sq3}, {5'h00, ~d[2:0]});
         chk({5'h00, sq4}, {5'h00, d[2:0] ^ 3'h6});
         rd(`HPTR_P3_SQ_OFS, r); chk(r, {5'h00, ~d[2:0]});
         rd(`HPTR_P4_SQ_OFS, r); chk(r, {5'h00, d[2:0] ^ 3'h6});
      end
   endtask
   task automatic t_link;
      for (v = 8'h00; v < 8'h0C; v++) begin
         @(posedge clk);
         p2_ls <= hptr_pkg::hptr_link_state_t'(v[3:0]); p2_sub <= v[2:0];
         p3_ls <= hptr_pkg::hptr_link_state_t'(4'hB - v[3:0]); p3_sub <= ~v[2:0];
         wr(`HPTR_P2_LINK_OFS, 8'hFF); wr(`HPTR_P2_SQ_OFS + 16'h0001, 8'hFF);
         wr(`HPTR_P3_LINK_OFS, 8'hFF);
         rd(`HPTR_P2_LINK_OFS, r); chk(r, {v[3:0], 1'b0, v[2:0]});
         rd(`HPTR_P3_LINK_OFS, r); chk(r, {4'hB - v[3:0], 1'b0, ~v[2:0]});
         rd(`HPTR_P2_SQ_OFS + 16'h0001, r); chk(r, 8'h00);
         rd(`HPTR_P2_LINK_OFS + 16'h0001, r); chk(r, 8'h00);
         chk({5'h00, sq2}, 8'h07);
      end
   endtask
   task automatic results;
      $display("Checks %0d, errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #200000;
      err_count++;
      results();
   end
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_drive();
      t_squelch();
      t_b2b();
      t_link();
      t_rerst();
      results();
   end
endmodule
`default_nettype wire
